// >>> core/reset_source_map.svh
`ifndef RESET_SOURCE_MAP_SVH
`define RESET_SOURCE_MAP_SVH

// Bit positions inside the reset source register.
`define POR_FLAG_BIT 7
`define STOP_FLAG_BIT 6
`define WDT_FLAG_BIT 5
`define EXTERNAL_RESET_FLAG_BIT 4

// Value after a power-on reset: only the power-on flag is set.
`define RESET_SOURCE_RESET_VAL 8'h80
// Mask that keeps the lower four bits when the register is read.
`define RESET_SOURCE_KEEP_MASK 8'h0f
// Watchdog control value after reset.
`define WDT_CTRL_RESET_VAL 8'h00

// Timing of the reset pin glitch filter.
`define CLK_PERIOD_NS 50
`define PIN_FILTER_NS 12
`define PIN_FILTER_CYC \
  (((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// Break length on the debug line, in bit periods.
`define BREAK_BITS 9
// Data bits in one debug character.
`define CHAR_BITS 8

`endif

// >>> core/reset_source_pkg.sv
`default_nettype none

package reset_source_pkg;

  // Error conditions seen by the debug unit, one pulse each.
  typedef struct packed {
    logic brk;
    logic framing;
    logic collision;
  } debug_err_t;

  // Receiver states of the debug line monitor.
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

endpackage : reset_source_pkg

`default_nettype wire

// >>> core/debug_error_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_map.svh"

module debug_error_monitor #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic line_i,
  input wire logic tx_oe_i,
  input wire logic tx_data_i,
  output var reset_source_pkg::debug_err_t err_o,
  output logic debug_reset_o
);
  import reset_source_pkg::*;

  localparam int BREAK_CYC = `BREAK_BITS * BIT_CYC;
  localparam int CW = $clog2(BREAK_CYC + 1);
  localparam int BW = $clog2(BIT_CYC + 1);

  if (BIT_CYC < 4) begin : g_bad_bit
    $error("BIT_CYC must be at least 4");
  end

  logic [CW-1:0] low_cnt_reg;
  logic [BW-1:0] bit_cnt_reg;
  logic [3:0] bit_idx_reg;
  rx_state_t state_reg;
  logic line_prev_reg;
  logic [1:0] tx_oe_dly_reg;
  logic [1:0] tx_data_dly_reg;
  debug_err_t err_next;

  // Counts consecutive low cycles on the line, saturating.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt_reg <= '0;
    end else if (line_i) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != CW'(BREAK_CYC)) begin
      low_cnt_reg <= low_cnt_reg + CW'(1);
    end
  end

  // Delays the transmit drive to line up with the synchronised line.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_oe_dly_reg <= 2'h0;
      tx_data_dly_reg <= 2'h3;
      line_prev_reg <= 1'b1;
    end else begin
      tx_oe_dly_reg <= {tx_oe_dly_reg[0], tx_oe_i};
      tx_data_dly_reg <= {tx_data_dly_reg[0], tx_data_i};
      line_prev_reg <= line_i;
    end
  end

  // Follows one character bit by bit; only the start and stop bits are sampled, each in its middle.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= RX_IDLE;
      bit_cnt_reg <= '0;
      bit_idx_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        RX_IDLE: begin
          if (line_prev_reg && !line_i) begin
            state_reg <= RX_START;
            bit_cnt_reg <= BW'(BIT_CYC / 2 - 1);
          end
        end
        RX_START: begin
          if (bit_cnt_reg != '0) begin
            bit_cnt_reg <= bit_cnt_reg - BW'(1);
          end else if (line_i) begin
            state_reg <= RX_IDLE;
          end else begin
            state_reg <= RX_DATA;
            bit_cnt_reg <= BW'(BIT_CYC - 1);
            bit_idx_reg <= 4'h0;
          end
        end
        RX_DATA: begin
          if (bit_cnt_reg != '0) begin
            bit_cnt_reg <= bit_cnt_reg - BW'(1);
          end else begin
            bit_cnt_reg <= BW'(BIT_CYC - 1);
            bit_idx_reg <= bit_idx_reg + 4'h1;
            if (bit_idx_reg == 4'(`CHAR_BITS - 1)) begin
              state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (bit_cnt_reg != '0) begin
            bit_cnt_reg <= bit_cnt_reg - BW'(1);
          end else begin
            state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Error detection feeding the registered error pulses.
  always_comb begin
    err_next = '0;
    // (RULE4) Break detection point.
    err_next.brk = !line_i && (low_cnt_reg == CW'(BREAK_CYC - 1));
    // (RULE5) Framing error check.
    err_next.framing = (state_reg == RX_STOP) && (bit_cnt_reg == '0) &&
      !line_i;
    // (RULE6) Collision on release.
    err_next.collision = tx_oe_dly_reg[1] && tx_data_dly_reg[1] && !line_i;
  end

  // Registers the error pulses and the debug reset request.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_o <= '0;
      debug_reset_o <= 1'b0;
    end else begin
      err_o <= err_next;
      debug_reset_o <= |err_next;
    end
  end

  // Own run length of low samples, so the break check does not lean on
  // the counter that it guards.
  int low_run;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_run <= 0;
    end else if (line_i) begin
      low_run <= 0;
    end else if (low_run < BREAK_CYC) begin
      low_run <= low_run + 1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_break_fires: assert property ( // RULE4
    (!line_i && low_run == BREAK_CYC - 1) |=> err_o.brk &&
      debug_reset_o)
    else $error("break did not raise a debug reset");
  a_break_not_early: assert property ( // RULE4
    err_o.brk |-> $past(low_run) == BREAK_CYC - 1)
    else $error("break flagged before nine low bit periods");
  a_err_needs_cause: assert property ( // RULE6
    debug_reset_o |-> $past(!line_i))
    else $error("debug reset without a low line");

endmodule : debug_error_monitor
`default_nettype wire

// >>> core/reset_source_recovery.sv
// Notes on behaviour
// (RULE1) Pin low in stop mode resets system.
// (RULE2) Short low pin pulses are ignored.
// (RULE3) Pin reset sets the external reset flag.
// (RULE4) Nine low bit periods start debug reset.
// (RULE5) Low stop bit starts debug reset.
// (RULE6) Transmit collision starts debug reset.
// (RULE7) Debug reset in stop mode resets system.
// (RULE8) Debug unit keeps state through that reset.
// (RULE9) That reset sets the power-on flag.
// (RULE10) Status register is read-only, shows latest cause.
// (RULE11) Reading clears the upper four bits afterwards.
// (RULE12) Reads give status, writes go to watchdog.
// (RULE13) Flags hold until read or new cause.
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_map.svh"

module reset_source_recovery #(
  parameter int SYSRST_CYC = 16,
  parameter int BIT_CYC = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic reset_pin_n_i,
  input wire logic debug_serial_pin_i,
  input wire logic debug_tx_oe_i,
  input wire logic debug_tx_data_i,
  input wire logic stop_mode_i,
  input wire logic wdt_timeout_i,
  input wire logic status_rd_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  output logic [7:0] status_rdata_o,
  output logic status_rvalid_o,
  output logic [7:0] wdt_ctrl_o,
  output logic wdt_ctrl_wr_o,
  output logic sys_reset_o,
  output var reset_source_pkg::debug_err_t debug_err_o
);
  import reset_source_pkg::*;

  localparam int FILT = `PIN_FILTER_CYC;
  localparam int FW = $clog2(FILT + 1);
  localparam int HW = $clog2(SYSRST_CYC + 1);

  if (SYSRST_CYC < 1) begin : g_bad_hold
    $error("SYSRST_CYC must be at least 1");
  end

  logic pin_meta_reg;
  logic pin_sync_reg;
  logic line_meta_reg;
  logic line_sync_reg;
  logic [FW-1:0] low_cnt_reg;
  logic [FW-1:0] low_cnt_next;
  logic pin_filt_reg;
  logic pin_filt_next;
  logic pin_evt;
  logic debug_reset;
  logic debug_stop_evt;
  logic any_evt;
  logic [HW-1:0] hold_cnt_reg;
  logic [HW-1:0] hold_cnt_next;
  logic [7:0] status_reg;
  logic [7:0] cause;

  // Builds a cause value, adding the stop flag when asleep.
  function automatic logic [7:0] cause_val(input int bit_pos,
                                           input logic in_stop);
    logic [7:0] v;
    v = 8'h00;
    v[bit_pos] = 1'b1;
    v[`STOP_FLAG_BIT] = in_stop;
    return v;
  endfunction : cause_val

  // Two-stage synchronisers for both pins.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      line_meta_reg <= 1'b1;
      line_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= reset_pin_n_i;
      pin_sync_reg <= pin_meta_reg;
      line_meta_reg <= debug_serial_pin_i;
      line_sync_reg <= line_meta_reg;
    end
  end

  // Glitch filter: the pin must stay low for the full width.
  always_comb begin
    low_cnt_next = low_cnt_reg;
    // (RULE2) Low width counting.
    if (pin_sync_reg) begin
      low_cnt_next = '0;
    end else if (low_cnt_reg != FW'(FILT)) begin
      low_cnt_next = low_cnt_reg + FW'(1);
    end
    pin_filt_next = (low_cnt_next == FW'(FILT));
  end

  // Filter state.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt_reg <= '0;
      pin_filt_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      pin_filt_reg <= pin_filt_next;
    end
  end

  // The debug unit runs only on the power-on reset, not on sys_reset_o.
  // (RULE8) Debug unit isolation.
  debug_error_monitor #(
    .BIT_CYC(BIT_CYC)
  ) u_debug_mon (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .line_i(line_sync_reg),
    .tx_oe_i(debug_tx_oe_i),
    .tx_data_i(debug_tx_data_i),
    .err_o(debug_err_o),
    .debug_reset_o(debug_reset)
  );

  // Events and the cause they report, pin first.
  always_comb begin
    pin_evt = pin_filt_next && !pin_filt_reg;
    // (RULE7) Debug reset in stop.
    debug_stop_evt = debug_reset && stop_mode_i;
    any_evt = pin_evt || debug_stop_evt || wdt_timeout_i;
    if (pin_evt) begin
      // (RULE3) External reset cause.
      cause = cause_val(`EXTERNAL_RESET_FLAG_BIT, stop_mode_i);
    end else if (debug_stop_evt) begin
      // (RULE9) Power-on cause.
      cause = cause_val(`POR_FLAG_BIT, 1'b0);
    end else begin
      cause = cause_val(`WDT_FLAG_BIT, stop_mode_i);
    end
  end

  // System reset stretcher, held while the pin is low as well.
  always_comb begin
    hold_cnt_next = hold_cnt_reg;
    // (RULE1) Pin drives system reset.
    if (pin_filt_next || debug_stop_evt) begin
      hold_cnt_next = HW'(SYSRST_CYC);
    end else if (hold_cnt_reg != '0) begin
      hold_cnt_next = hold_cnt_reg - HW'(1);
    end
  end

  // Reset output register.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_cnt_reg <= '0;
      sys_reset_o <= 1'b0;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
      sys_reset_o <= (hold_cnt_next != '0);
    end
  end

  // Status register: a new cause wins over the read clear.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg <= `RESET_SOURCE_RESET_VAL;
    end else if (any_evt) begin
      // (RULE13) Latest cause overwrites.
      status_reg <= cause;
    end else if (status_rd_i) begin
      // (RULE11) Read clears upper bits.
      status_reg <= status_reg & `RESET_SOURCE_KEEP_MASK;
    end
  end

  // Read port returns the value before the clear.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_rdata_o <= 8'h00;
      status_rvalid_o <= 1'b0;
    end else begin
      // (RULE10) Read-only status view.
      status_rvalid_o <= status_rd_i;
      if (status_rd_i) begin
        status_rdata_o <= status_reg;
      end
    end
  end

  // Writes at the shared address land in the watchdog control.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdt_ctrl_o <= `WDT_CTRL_RESET_VAL;
      wdt_ctrl_wr_o <= 1'b0;
    end else begin
      // (RULE12) Shared address split.
      wdt_ctrl_wr_o <= ctrl_wr_i;
      if (ctrl_wr_i) begin
        wdt_ctrl_o <= ctrl_wdata_i;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_pin_sets_flag: assert property ( // RULE3
    $rose(pin_filt_reg) |-> status_reg[`EXTERNAL_RESET_FLAG_BIT] &&
      status_reg[`STOP_FLAG_BIT] == $past(stop_mode_i))
    else $error("pin reset did not set the external flag");
  a_pin_holds_reset: assert property ( // RULE1
    pin_filt_reg |-> sys_reset_o)
    else $error("filtered pin low without system reset");
  a_short_ignored: assert property ( // RULE2
    $rose(pin_filt_reg) |-> $past(!pin_sync_reg))
    else $error("reset taken without a low pin");
  a_debug_stop_por: assert property ( // RULE9
    (debug_reset && stop_mode_i && !pin_evt) |=>
      status_reg == `RESET_SOURCE_RESET_VAL && sys_reset_o)
    else $error("debug reset in stop mode mishandled");
  a_debug_run_quiet: assert property ( // RULE7
    (debug_reset && !stop_mode_i && !pin_filt_next &&
     hold_cnt_reg == '0) |=> !sys_reset_o)
    else $error("debug reset outside stop mode reset the system");
  a_read_data: assert property ( // RULE11
    status_rd_i |=> status_rvalid_o && status_rdata_o == $past(status_reg))
    else $error("read returned the wrong value");
  a_read_clears: assert property ( // RULE11
    (status_rd_i && !any_evt) |=> status_reg[7:4] == 4'h0 &&
      status_reg[3:0] == $past(status_reg[3:0]))
    else $error("read did not clear the upper bits");
  a_flags_hold: assert property ( // RULE13
    (!any_evt && !status_rd_i) |=> $stable(status_reg))
    else $error("status changed without a cause");
  a_write_to_wdt: assert property ( // RULE12
    (ctrl_wr_i && !any_evt && !status_rd_i) |=> wdt_ctrl_wr_o &&
      wdt_ctrl_o == $past(ctrl_wdata_i) && $stable(status_reg))
    else $error("write did not reach watchdog control");

  c_pin_in_stop: cover property (pin_evt && stop_mode_i);
  c_debug_in_stop: cover property (debug_stop_evt ##1 sys_reset_o);
  c_read_clear: cover property (status_rd_i && status_reg[7:4] != 4'h0);
  c_event_on_read: cover property (status_rd_i && any_evt);

endmodule : reset_source_recovery
`default_nettype wire

// >>> bench/debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module debug_host_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk_i,
  output logic reset_pin_n_o,
  output logic host_low_o
);
  // Both lines have pull-ups, so the idle level is released (high).
  initial begin
    reset_pin_n_o = 1'b1;
    host_low_o = 1'b0;
  end

  // Pulls the reset pin low for whole clock cycles.
  task automatic pin_low(input int cyc);
    @(negedge clk_i);
    reset_pin_n_o = 1'b0;
    repeat (cyc) @(negedge clk_i);
    reset_pin_n_o = 1'b1;
  endtask : pin_low

  // A 10 ns low pulse placed away from any rising clock edge.
  task automatic glitch;
    @(negedge clk_i);
    #5 reset_pin_n_o = 1'b0;
    #10 reset_pin_n_o = 1'b1;
  endtask : glitch

  // Holds the debug line low for a number of clock cycles.
  task automatic line_low(input int cyc);
    @(negedge clk_i);
    host_low_o = 1'b1;
    repeat (cyc) @(negedge clk_i);
    host_low_o = 1'b0;
  endtask : line_low

  // Sends start, eight data bits first-LSB, then the given stop level.
  task automatic send_char(input logic [7:0] d, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      host_low_o = ~frame[i];
      repeat (BIT_CYC - 1) @(negedge clk_i);
    end
    @(negedge clk_i);
    host_low_o = 1'b0;
  endtask : send_char
endmodule : debug_host_model

`default_nettype wire

// >>> bench/reset_source_recovery_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module reset_source_recovery_tb_top;
  import reset_source_pkg::*;
  localparam int BIT_CYC = 4;
  localparam int SYSRST_CYC = 2;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic tx_oe = 1'b0;
  logic tx_data = 1'b1;
  logic wdt_timeout_i = 1'b0;
  logic status_rd_i = 1'b0;
  logic ctrl_wr_i = 1'b0;
  logic [7:0] ctrl_wdata_i = 8'h00;
  wire pin_n;
  wire host_low;
  wire line;
  logic [7:0] status_rdata_o;
  logic status_rvalid_o;
  logic [7:0] wdt_ctrl_o;
  logic wdt_ctrl_wr_o;
  logic sys_reset_o;
  debug_err_t debug_err_o;
  logic [2:0] seen_err = 3'h0;
  logic seen_rst = 1'b0;
  logic seen_clr = 1'b0;
  int miscompares = 0;
  int checks = 0;

  always #25 clk_i = ~clk_i;

  // The debug line is pulled up; either party may pull it low.
  assign line = ~(host_low | (tx_oe & ~tx_data));

  // Sticky record of error pulses and system reset requests.
  // A clear request empties the record at the next rising edge.
  always @(posedge clk_i) begin
    if (seen_clr) begin
      seen_err <= 3'h0;
      seen_rst <= 1'b0;
    end else begin
      seen_err <= seen_err | debug_err_o;
      seen_rst <= seen_rst | sys_reset_o;
    end
  end

  debug_host_model #(.BIT_CYC(BIT_CYC)) u_host (
    .clk_i(clk_i),
    .reset_pin_n_o(pin_n),
    .host_low_o(host_low)
  );

  reset_source_recovery #(.SYSRST_CYC(SYSRST_CYC), .BIT_CYC(BIT_CYC)) u_dut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .reset_pin_n_i(pin_n),
    .debug_serial_pin_i(line),
    .debug_tx_oe_i(tx_oe),
    .debug_tx_data_i(tx_data),
    .stop_mode_i(stop_mode_i),
    .wdt_timeout_i(wdt_timeout_i),
    .status_rd_i(status_rd_i),
    .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i),
    .status_rdata_o(status_rdata_o),
    .status_rvalid_o(status_rvalid_o),
    .wdt_ctrl_o(wdt_ctrl_o),
    .wdt_ctrl_wr_o(wdt_ctrl_wr_o),
    .sys_reset_o(sys_reset_o),
    .debug_err_o(debug_err_o)
  );

  // Compares one byte and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Reads the status register and checks the answer one cycle later.
  task automatic read_chk(input logic [7:0] exp);
    @(negedge clk_i) status_rd_i = 1'b1;
    @(negedge clk_i) status_rd_i = 1'b0;
    chk({7'h00, status_rvalid_o}, 8'h01);
    chk(status_rdata_o, exp);
  endtask : read_chk

  // Asks the sticky record to forget everything seen so far.
  task automatic clear_seen;
    @(negedge clk_i) seen_clr = 1'b1;
    @(negedge clk_i) seen_clr = 1'b0;
  endtask : clear_seen

  task automatic t_regs;
    chk({sys_reset_o, debug_err_o, wdt_ctrl_wr_o, status_rvalid_o, 2'b00},
        8'h00);
    chk(wdt_ctrl_o, 8'h00);
    read_chk(8'h80);
    read_chk(8'h00);
    @(negedge clk_i);
    ctrl_wr_i = 1'b1;
    ctrl_wdata_i = 8'ha5;
    @(negedge clk_i) ctrl_wr_i = 1'b0;
    chk({7'h00, wdt_ctrl_wr_o}, 8'h01);
    chk(wdt_ctrl_o, 8'ha5);
    read_chk(8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pin;
    clear_seen();
    u_host.glitch();
    repeat (8) @(negedge clk_i);
    chk({7'h00, seen_rst}, 8'h00);
    read_chk(8'h00);
    stop_mode_i = 1'b1;
    u_host.pin_low(4);
    chk({7'h00, seen_rst}, 8'h01);
    repeat (SYSRST_CYC + 8) @(negedge clk_i);
    chk({7'h00, sys_reset_o}, 8'h00);
    read_chk(8'h50);
    read_chk(8'h00);
    $display("test pin done");
  endtask : t_pin

  task automatic t_wdt;
    clear_seen();
    wdt_timeout_i = 1'b1;
    @(negedge clk_i) wdt_timeout_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk({7'h00, seen_rst}, 8'h00);
    read_chk(8'h60);
    $display("test watchdog done");
  endtask : t_wdt

  task automatic t_break;
    clear_seen();
    u_host.line_low(9 * BIT_CYC - 2);
    repeat (4 * BIT_CYC) @(negedge clk_i);
    chk({4'h0, seen_err, seen_rst}, 8'h00);
    u_host.line_low(9 * BIT_CYC + 8);
    repeat (SYSRST_CYC + 20) @(negedge clk_i);
    chk({7'h00, seen_err[2]}, 8'h01);
    chk({7'h00, seen_rst}, 8'h01);
    read_chk(8'h80);
    $display("test break done");
  endtask : t_break

  task automatic t_frame;
    stop_mode_i = 1'b0;
    clear_seen();
    u_host.send_char(8'h5a, 1'b1);
    repeat (6) @(negedge clk_i);
    chk({5'h00, seen_err}, 8'h00);
    u_host.send_char(8'h5a, 1'b0);
    repeat (6) @(negedge clk_i);
    chk({5'h00, seen_err}, 8'h02);
    chk({7'h00, seen_rst}, 8'h00);
    read_chk(8'h00);
    $display("test framing done");
  endtask : t_frame

  task automatic t_collision;
    @(negedge clk_i);
    tx_oe = 1'b1;
    tx_data = 1'b1;
    clear_seen();
    u_host.line_low(2 * BIT_CYC);
    repeat (12 * BIT_CYC) @(negedge clk_i);
    tx_oe = 1'b0;
    chk({5'h00, seen_err}, 8'h01);
    $display("test collision done");
  endtask : t_collision

  // Causes taken outside stop mode, one of them in a read cycle.
  task automatic t_run_causes;
    u_host.pin_low(2);
    repeat (SYSRST_CYC + 8) @(negedge clk_i);
    read_chk(8'h10);
    @(negedge clk_i);
    wdt_timeout_i = 1'b1;
    status_rd_i = 1'b1;
    @(negedge clk_i);
    wdt_timeout_i = 1'b0;
    status_rd_i = 1'b0;
    chk(status_rdata_o, 8'h00);
    read_chk(8'h20);
    $display("test run causes done");
  endtask : t_run_causes

  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (12) @(negedge clk_i);
    nrst_i = 1'b1;
    t_regs();
    t_pin();
    t_wdt();
    t_break();
    t_frame();
    t_collision();
    t_run_causes();
    end_sim();
  end
endmodule : reset_source_recovery_tb_top

`default_nettype wire
